// >>> hdl/cios_pkg.sv
// Constants for the channel I/O instruction sequencer
package cios_pkg;
  localparam logic [7:0] CIOS_CSW_ADDR = 8'h40;
  localparam logic [7:0] CIOS_CAW_ADDR = 8'h48;
  localparam logic [1:0] CIOS_CC_OK = 2'h0;
  localparam logic [1:0] CIOS_CC_STORED = 2'h1;
  localparam logic [1:0] CIOS_CC_BUSY = 2'h2;
  localparam logic [1:0] CIOS_CC_UNAVAIL = 2'h3;
  localparam int CIOS_STACK_BIT = 7;
  localparam int CIOS_CLK_MHZ = 125;
  localparam int CIOS_BUSY_US = 64;
  localparam int CIOS_BUSY_CYC = CIOS_BUSY_US * CIOS_CLK_MHZ;
  localparam logic [7:0] CIOS_CMD_READ = 8'h02;
  localparam logic [7:0] CIOS_CMD_RDBK = 8'h0C;
  localparam logic [7:0] CIOS_CMD_SENSE = 8'h04;
  localparam logic [7:0] CIOS_CMD_WRITE = 8'h01;
  localparam logic [1:0] CIOS_CMD_CTRL = 2'h3;
  typedef enum logic [1:0] {CIOS_NONE, CIOS_IN, CIOS_OUT} cios_dir_e;
endpackage

// >>> hdl/cios_word_store.sv
// Small word memory holding subchannel control words 0 and 2
`timescale 1ns/1ns
module cios_word_store
  import cios_pkg::*;
#(
  parameter int WIDTH = 64,
  parameter int DEPTH = 4
)
(
  input wire logic clk,
  input wire logic we,
  input wire logic [$clog2(DEPTH)-1:0] waddr,
  input wire logic [WIDTH-1:0] wdata,
  input wire logic [$clog2(DEPTH)-1:0] raddr,
  output logic [WIDTH-1:0] rdata
);
  logic [WIDTH-1:0] mem [DEPTH];

  always_ff @(posedge clk)
  begin
    if (we)
    begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end
endmodule

// >>> hdl/cios_sequencer.sv
// Main channel sequencer for test I/O and start I/O opening steps
`timescale 1ns/1ns
module cios_sequencer
  import cios_pkg::*;
#(
  parameter int BUSY_CYCLES = CIOS_BUSY_CYC
)
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic cpu_test_io,
  input wire logic cpu_start_io,
  input wire logic cpu_select_channel,
  input wire logic [7:0] unit_address_bus_out,
  output logic cpu_release,
  output logic [1:0] cpu_cond_code,
  input wire logic irq_queue_match,
  output logic priority_request,
  input wire logic main_channel_response,
  input wire logic response_delayed,
  input wire logic break_in_request,
  output logic storage_request,
  output logic [7:0] storage_address_register,
  output logic [63:0] storage_write_data,
  output logic [7:0] storage_marks,
  output logic storage_write,
  input wire logic storage_response,
  input wire logic storage_cycle_over,
  input wire logic storage_check,
  input wire logic [63:0] storage_read_data,
  input wire logic [3:0] main_check_latches,
  input wire logic [7:0] special_status,
  input wire logic [23:0] adder_latched,
  input wire logic stack_path_active,
  output logic ending,
  output logic command_required,
  output logic mx_initial_select,
  output logic [7:0] io_bus_out,
  output logic io_bus_out_parity,
  output logic command_out_block,
  output logic service_out,
  input wire logic io_command_out,
  input wire logic io_select_in,
  input wire logic io_address_in,
  input wire logic [7:0] io_bus_in,
  input wire logic io_status_in,
  input wire logic io_operational_in,
  input wire logic mx_burst_mode,
  input wire logic [7:0] ccw_command,
  output cios_dir_e ssc_direction,
  output logic ssc_select,
  input wire logic ssc_command_accept,
  output logic interface_busy
);
  typedef enum logic [3:0] {
    S_IDLE, S_TIO_READ0, S_TIO_CHK0, S_TIO_READ2, S_TIO_CHK2, S_MX_SEL,
    S_MX_STATUS, S_CSW_FORM, S_CSW_REQ, S_CSW_WAIT, S_SIO_REQ,
    S_CAW_REQ, S_CAW_WAIT, S_CCW_WAIT, S_RELEASE
  } cios_state_e;

  cios_state_e state_ff;
  logic [63:0] ctrl_reg_ff;
  logic [7:0] status_byte_ff;
  logic [1:0] cc_ff;
  logic stacked_ff;
  logic [7:0] addr_ff;
  logic [13:0] busy_cnt_ff;
  logic [4:0] sync_a_ff, sync_b_ff;
  logic [7:0] bus_in_a_ff, bus_in_b_ff;
  logic sel_in, sta_in, op_in, adr_in, cmd_out;
  logic [2:0] wipe_ff;
  logic wipe_busy;
  logic mem_we;
  logic [1:0] mem_waddr, mem_raddr;
  logic [63:0] mem_wdata, mem_rdata;

  // Device pins pass two flops before use
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      sync_a_ff <= 5'h00;
      sync_b_ff <= 5'h00;
      bus_in_a_ff <= 8'h00;
      bus_in_b_ff <= 8'h00;
    end
    else
    begin
      sync_a_ff <= {io_command_out, io_address_in, io_operational_in,
                    io_status_in, io_select_in};
      sync_b_ff <= sync_a_ff;
      bus_in_a_ff <= io_bus_in;
      bus_in_b_ff <= bus_in_a_ff;
    end
  end
  assign sel_in = sync_b_ff[0];
  assign sta_in = sync_b_ff[1];
  assign op_in = sync_b_ff[2];
  assign adr_in = sync_b_ff[3];
  assign cmd_out = sync_b_ff[4];

  cios_word_store #(.WIDTH(64), .DEPTH(4)) u_store (
    .clk(clk),
    .we(mem_we),
    .waddr(mem_waddr),
    .wdata(mem_wdata),
    .raddr(mem_raddr),
    .rdata(mem_rdata)
  );

  // Store powers up unknown, so it is wiped once before any instruction
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      wipe_ff <= 3'h0;
    end
    else if (wipe_busy)
    begin
      wipe_ff <= wipe_ff + 3'h1;
    end
  end
  assign wipe_busy = !wipe_ff[2];

  // Word 2 from the address word, word 0 from the command
  always_comb
  begin
    mem_we = wipe_busy;
    mem_waddr = wipe_ff[1:0];
    mem_wdata = 64'h0;
    if (wipe_busy)
    begin
      mem_we = 1'b1;
    end
    else if (state_ff == S_TIO_CHK0)
    begin
      mem_we = (mem_rdata[63-CIOS_STACK_BIT +: 2] == 2'b00);
      mem_waddr = 2'h0;
      mem_wdata = mem_rdata;
    end
    else if (state_ff == S_CAW_WAIT)
    begin
      mem_we = storage_cycle_over && !storage_check;
      mem_waddr = 2'h2;
      mem_wdata = storage_read_data;
    end
    else if (state_ff == S_CCW_WAIT)
    begin
      mem_we = ssc_command_accept;
      mem_waddr = 2'h0;
      mem_wdata = {ccw_command, 56'h0};
    end
  end
  assign mem_raddr = (state_ff == S_TIO_READ2 || state_ff == S_TIO_CHK2
                     || stacked_ff) ? 2'h2 : 2'h0;

  // Busy timer for a multiplex interface stuck in burst mode
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      busy_cnt_ff <= 14'h0000;
    end
    else if (state_ff == S_MX_SEL && mx_burst_mode && op_in)
    begin
      if (busy_cnt_ff != 14'(BUSY_CYCLES))
      begin
        busy_cnt_ff <= busy_cnt_ff + 14'h0001;
      end
    end
    else
    begin
      busy_cnt_ff <= 14'h0000;
    end
  end
  assign interface_busy = (busy_cnt_ff == 14'(BUSY_CYCLES));

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state_ff <= S_IDLE;
      cc_ff <= CIOS_CC_OK;
      stacked_ff <= 1'b0;
      addr_ff <= 8'h00;
      status_byte_ff <= 8'h00;
      ending <= 1'b0;
      command_required <= 1'b0;
      mx_initial_select <= 1'b0;
      service_out <= 1'b0;
      ssc_select <= 1'b0;
    end
    else
    begin
      ending <= 1'b0;
      unique case (state_ff)
        S_IDLE:
        begin
          service_out <= 1'b0;
          if (cpu_select_channel && cpu_test_io && !wipe_busy)
          begin
            stacked_ff <= 1'b0;
            addr_ff <= unit_address_bus_out;
            state_ff <= irq_queue_match ? S_CSW_REQ : S_TIO_READ0;
          end
          else if (cpu_select_channel && cpu_start_io && !wipe_busy)
          begin
            addr_ff <= unit_address_bus_out;
            state_ff <= S_SIO_REQ;
          end
        end
        S_TIO_READ0:
          state_ff <= S_TIO_CHK0;
        S_TIO_CHK0:
          if (mem_rdata[63-CIOS_STACK_BIT +: 2] == 2'b00)
          begin
            stacked_ff <= 1'b0;
            mx_initial_select <= 1'b1;
            ending <= 1'b1;
            state_ff <= S_MX_SEL;
          end
          else
          begin
            state_ff <= S_TIO_READ2;
          end
        S_TIO_READ2:
          state_ff <= S_TIO_CHK2;
        S_TIO_CHK2:
          if (mem_rdata[63-CIOS_STACK_BIT])
          begin
            stacked_ff <= 1'b1;
            mx_initial_select <= 1'b1;
            ending <= 1'b1;
            state_ff <= S_MX_SEL;
          end
          else
          begin
            cc_ff <= CIOS_CC_BUSY;
            state_ff <= S_RELEASE;
          end
        S_MX_SEL:
          if (interface_busy)
          begin
            mx_initial_select <= 1'b0;
            cc_ff <= CIOS_CC_BUSY;
            state_ff <= S_RELEASE;
          end
          else if (!mx_burst_mode
                   && (sel_in || (adr_in && bus_in_b_ff != addr_ff)))
          begin
            mx_initial_select <= 1'b0;
            cc_ff <= CIOS_CC_UNAVAIL;
            state_ff <= S_RELEASE;
          end
          else if (!mx_burst_mode && sta_in)
          begin
            status_byte_ff <= bus_in_b_ff;
            state_ff <= S_MX_STATUS;
          end
        S_MX_STATUS:
          if (status_byte_ff == 8'h00)
          begin
            mx_initial_select <= 1'b0;
            service_out <= 1'b1;
            cc_ff <= CIOS_CC_OK;
            state_ff <= S_RELEASE;
          end
          else if (main_channel_response && response_delayed)
          begin
            mx_initial_select <= 1'b0;
            service_out <= 1'b1;
            state_ff <= S_CSW_FORM;
          end
        S_CSW_FORM:
          state_ff <= S_CSW_REQ;
        S_CSW_REQ:
          if (storage_response)
          begin
            state_ff <= S_CSW_WAIT;
          end
        S_CSW_WAIT:
          if (storage_cycle_over)
          begin
            cc_ff <= CIOS_CC_STORED;
            ending <= stacked_ff;
            state_ff <= S_RELEASE;
          end
        S_SIO_REQ:
          if (main_channel_response && response_delayed)
          begin
            state_ff <= S_CAW_REQ;
          end
        S_CAW_REQ:
          if (storage_response)
          begin
            state_ff <= S_CAW_WAIT;
          end
        S_CAW_WAIT:
          if (storage_cycle_over && storage_check)
          begin
            cc_ff <= CIOS_CC_STORED;
            state_ff <= S_RELEASE;
          end
          else if (storage_cycle_over && !break_in_request)
          begin
            command_required <= 1'b1;
            ssc_select <= 1'b1;
            state_ff <= S_CCW_WAIT;
          end
          else if (storage_cycle_over)
          begin
            ending <= 1'b1;
            state_ff <= S_SIO_REQ;
          end
        S_CCW_WAIT:
          if (ssc_command_accept)
          begin
            command_required <= 1'b0;
            ssc_select <= 1'b0;
            cc_ff <= CIOS_CC_OK;
            state_ff <= S_RELEASE;
          end
        S_RELEASE:
          if (!cpu_test_io && !cpu_start_io)
          begin
            service_out <= 1'b0;
            state_ff <= S_IDLE;
          end
      endcase
    end
  end

  // Status word assembly in the control register
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      ctrl_reg_ff <= 64'h0;
    end
    else if (state_ff == S_MX_STATUS && stacked_ff)
    begin
      ctrl_reg_ff[63:56] <= 8'h00;
      ctrl_reg_ff[55:32] <= mem_rdata[55:32];
      ctrl_reg_ff[31:24] <= status_byte_ff;
      ctrl_reg_ff[23:16] <= special_status
                            | {1'b0, main_check_latches, 3'h0};
      ctrl_reg_ff[15:0] <= adder_latched[15:0];
      ctrl_reg_ff[63 - CIOS_STACK_BIT] <= 1'b0;
    end
    else if (state_ff == S_MX_STATUS)
    begin
      ctrl_reg_ff <= 64'h0;
      ctrl_reg_ff[31:24] <= status_byte_ff;
      ctrl_reg_ff[23:16] <= special_status;
    end
  end

  assign storage_write_data = ctrl_reg_ff;
  assign storage_marks = 8'hFF;
  assign storage_write = (state_ff == S_CSW_REQ);
  assign storage_request = (state_ff == S_CSW_REQ)
                           || (state_ff == S_CAW_REQ);
  assign storage_address_register = (state_ff == S_CAW_REQ)
                                    ? CIOS_CAW_ADDR
                                    : CIOS_CSW_ADDR;
  assign priority_request = cpu_start_io && cpu_select_channel
                            && !mx_initial_select && !cpu_release
                            && !main_channel_response
                            && state_ff == S_SIO_REQ;
  assign cpu_release = (state_ff == S_RELEASE);
  assign cpu_cond_code = cc_ff;
  assign command_out_block = cpu_test_io && mx_initial_select
                             && cmd_out;
  assign io_bus_out = command_out_block ? 8'h00 : addr_ff;
  assign io_bus_out_parity = ~(^io_bus_out);

  // Command grouping for the selector subchannel
  always_comb
  begin
    ssc_direction = CIOS_NONE;
    if (ccw_command == CIOS_CMD_READ || ccw_command == CIOS_CMD_RDBK
        || ccw_command == CIOS_CMD_SENSE)
    begin
      ssc_direction = CIOS_IN;
    end
    else if (ccw_command == CIOS_CMD_WRITE
             || ccw_command[1:0] == CIOS_CMD_CTRL)
    begin
      ssc_direction = CIOS_OUT;
    end
  end
endmodule

// >>> testbench/cios_sva.sv
// Port checks for the channel I/O instruction sequencer
`timescale 1ns/1ns
module cios_sva
  import cios_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic cpu_test_io,
  input wire logic cpu_start_io,
  input wire logic cpu_select_channel,
  input wire logic main_channel_response,
  input wire logic priority_request,
  input wire logic cpu_release,
  input wire logic [1:0] cpu_cond_code,
  input wire logic storage_request,
  input wire logic storage_write,
  input wire logic [7:0] storage_address_register,
  input wire logic [7:0] storage_marks,
  input wire logic command_out_block,
  input wire logic [7:0] io_bus_out,
  input wire logic io_bus_out_parity,
  input wire logic ending,
  input wire logic interface_busy
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);
  sequence s_busy_rel;
    ##[0:4] (cpu_release && cpu_cond_code == CIOS_CC_BUSY);
  endsequence
  a_prio_cause: assert property (priority_request |-> cpu_start_io &&
    cpu_select_channel && !main_channel_response && !cpu_release)
    else $error("priority request without cause");
  a_csw_addr: assert property (storage_write |->
    storage_address_register == CIOS_CSW_ADDR)
    else $error("status word not at 64");
  a_all_marks: assert property (storage_write |-> storage_marks == 8'hFF)
    else $error("status word marks incomplete");
  a_zero_cmd: assert property (command_out_block |->
    io_bus_out == 8'h00 && io_bus_out_parity)
    else $error("command byte not blocked");
  a_busy_release: assert property (interface_busy && cpu_test_io |-> s_busy_rel)
    else $error("busy interface not released with 10");
  a_release_stands: assert property (cpu_release &&
    (cpu_test_io || cpu_start_io) |=> cpu_release)
    else $error("release dropped early");
  a_ending_pulse: assert property (ending |=> !ending)
    else $error("ending longer than a cycle");
  a_caw_addr: assert property (storage_request && cpu_start_io &&
    !storage_write |-> storage_address_register == CIOS_CAW_ADDR)
    else $error("address word not at 72");
endmodule

// >>> testbench/cios_far_model.sv
// Storage controller, I/O unit and grant model facing the sequencer
`timescale 1ns/1ns
module cios_far_model
  import cios_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic slow,
  input wire logic answers,
  input wire logic wrong_unit,
  input wire logic [7:0] unit_address_bus_out,
  input wire logic [7:0] unit_status,
  input wire logic storage_request,
  input wire logic mx_initial_select,
  input wire logic service_out,
  input wire logic priority_request,
  input wire logic cpu_release,
  input wire logic ssc_select,
  output logic storage_response,
  output logic storage_cycle_over,
  output logic main_channel_response,
  output logic response_delayed,
  output logic ssc_command_accept,
  output logic io_select_in,
  output logic io_address_in,
  output logic io_command_out,
  output logic io_status_in,
  output logic [7:0] io_bus_in
);
  logic [3:0] st_ff;
  logic [2:0] un_ff;
  logic [3:0] lat;
  assign lat = slow ? 4'h5 : 4'h1;
  assign storage_response = st_ff == lat;
  assign storage_cycle_over = st_ff == lat + 4'h2;
  // Select in comes back only when no unit takes the selection
  assign io_select_in = un_ff == 3'h6;
  assign io_address_in = un_ff == 3'h2;
  assign io_command_out = un_ff == 3'h3;
  assign io_status_in = un_ff == 3'h4;
  // Released bus shows the inverse, never a stale byte
  assign io_bus_in = io_address_in
    ? (wrong_unit ? ~unit_address_bus_out : unit_address_bus_out)
    : (io_status_in ? unit_status : ~unit_status);
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      st_ff <= 4'h0;
    else if (storage_cycle_over)
      st_ff <= 4'h0;
    else if (st_ff != 4'h0 || storage_request)
      st_ff <= st_ff + 4'h1;
  end
  // Grant held until release, channel stays busy meanwhile
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      main_channel_response <= 1'b0;
      response_delayed <= 1'b0;
      ssc_command_accept <= 1'b0;
    end
    else
    begin
      main_channel_response <= (priority_request || main_channel_response
        || (io_status_in && mx_initial_select && unit_status != 8'h00))
        && !cpu_release;
      response_delayed <= main_channel_response;
      ssc_command_accept <= ssc_select;
    end
  end
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      un_ff <= 3'h0;
    else if (un_ff == 3'h0 && mx_initial_select)
      un_ff <= answers ? 3'h1 : 3'h6;
    else if (un_ff != 3'h0 && un_ff < 3'h4)
      un_ff <= un_ff + 3'h1;
    else if (un_ff == 3'h4 && (service_out || !mx_initial_select))
      un_ff <= 3'h5;
    else if (un_ff >= 3'h5 && !mx_initial_select)
      un_ff <= 3'h0;
  end
endmodule

// >>> testbench/cios_sequencer_tb_top.sv
// Self-checking bench for the channel I/O instruction sequencer
`timescale 1ns/1ns
module cios_sequencer_tb_top
  import cios_pkg::*;
;
  logic clk, reset_n, cpu_test_io, cpu_start_io, cpu_select_channel;
  logic irq_queue_match, break_in_request, storage_check, stack_path_active;
  logic mx_burst_mode, io_operational_in, slow, answers, wrong_unit;
  logic [7:0] unit_address_bus_out, special_status, ccw_command, unit_status;
  logic [3:0] main_check_latches;
  logic [23:0] adder_latched;
  logic [63:0] storage_read_data, storage_write_data, channel_status_word;
  logic [7:0] storage_address_register, storage_marks, io_bus_out, io_bus_in;
  logic [1:0] cpu_cond_code;
  logic cpu_release, priority_request, main_channel_response, saw_cr;
  logic response_delayed, storage_request, storage_write, storage_response;
  logic storage_cycle_over, ending, command_required, mx_initial_select;
  logic io_bus_out_parity, command_out_block, service_out, io_command_out;
  logic io_select_in, io_address_in, io_status_in, ssc_select;
  logic ssc_command_accept, interface_busy;
  cios_dir_e ssc_direction, dir_seen;
  int err_total = 0;
  int comparisons = 0;
  logic [7:0] cmds [5] = '{CIOS_CMD_READ, CIOS_CMD_RDBK, CIOS_CMD_SENSE,
    CIOS_CMD_WRITE, {6'h00, CIOS_CMD_CTRL}};
  cios_dir_e dirs [5] = '{CIOS_IN, CIOS_IN, CIOS_IN, CIOS_OUT, CIOS_OUT};

  cios_sequencer #(.BUSY_CYCLES(20)) u_cios_sequencer (.*);
  cios_far_model u_cios_far_model (.*);

  always #4 clk = ~clk;
  always @(posedge clk)
    if (storage_write && storage_response)
      channel_status_word <= storage_write_data;

  task automatic chk(input logic ok, input string m);
    comparisons++;
    if (ok !== 1'b1)
    begin
      err_total++;
      $display("BAD %0t %s", $time, m);
    end
  endtask

  task automatic complete_run();
    $display("Compares %0d, mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // One instruction: raise lines, wait release, drop lines
  task automatic instr(input logic tst, input logic [1:0] cc);
    int n;
    n = 0;
    saw_cr = 1'b0;
    @(negedge clk);
    cpu_test_io = tst;
    cpu_start_io = !tst;
    cpu_select_channel = 1'b1;
    while (cpu_release !== 1'b1 && n < 600)
    begin
      @(negedge clk);
      n++;
      if (command_required === 1'b1)
        saw_cr = 1'b1;
      if (ssc_select === 1'b1)
        dir_seen = ssc_direction;
    end
    chk(n < 600, "release timeout");
    chk(cpu_cond_code === cc, "condition code");
    cpu_test_io = 1'b0;
    cpu_start_io = 1'b0;
    cpu_select_channel = 1'b0;
    repeat (3) @(negedge clk);
  endtask

  initial
  begin
    {clk, reset_n, cpu_test_io, cpu_start_io, cpu_select_channel} = '0;
    {irq_queue_match, break_in_request, storage_check, slow, wrong_unit} = '0;
    {stack_path_active, mx_burst_mode, io_operational_in} = '0;
    {special_status, main_check_latches, unit_status} = '0;
    answers = 1'b1;
    adder_latched = 24'h000000;
    storage_read_data = 64'h0112_3456_0000_1000;
    unit_address_bus_out = 8'h1A;
    ccw_command = CIOS_CMD_READ;
    dir_seen = CIOS_NONE;
    repeat (10) @(negedge clk);
    reset_n = 1'b1;
    chk(storage_address_register === CIOS_CSW_ADDR, "reset address");
    chk(io_bus_out_parity === 1'b1 && cpu_release === 1'b0, "reset outputs");
    instr(1'b1, CIOS_CC_OK);
    unit_status = 8'h0C;
    special_status = 8'h80;
    main_check_latches = 4'hF;
    slow = 1'b1;
    instr(1'b1, CIOS_CC_STORED);
    chk(channel_status_word === {32'h0, 8'h0C, 8'h80, 16'h0}, "status word");
    {unit_status, special_status, main_check_latches, slow} = '0;
    answers = 1'b0;
    instr(1'b1, CIOS_CC_UNAVAIL);
    answers = 1'b1;
    wrong_unit = 1'b1;
    instr(1'b1, CIOS_CC_UNAVAIL);
    wrong_unit = 1'b0;
    mx_burst_mode = 1'b1;
    io_operational_in = 1'b1;
    instr(1'b1, CIOS_CC_BUSY);
    mx_burst_mode = 1'b0;
    io_operational_in = 1'b0;
    irq_queue_match = 1'b1;
    instr(1'b1, CIOS_CC_STORED);
    irq_queue_match = 1'b0;
    for (int i = 0; i < 5; i++)
    begin
      ccw_command = cmds[i];
      dir_seen = CIOS_NONE;
      instr(1'b0, CIOS_CC_OK);
      chk(dir_seen === dirs[i], "command direction");
      chk(saw_cr === 1'b1, "command required");
    end
    // Last command left word 0 busy; word 2 carries the stack flag
    unit_status = 8'h0C;
    special_status = 8'h80;
    main_check_latches = 4'h5;
    adder_latched = 24'h00BEEF;
    instr(1'b1, CIOS_CC_STORED);
    chk(channel_status_word === {8'h00, 24'h123456, 8'h0C, 8'hA8, 16'hBEEF}, "stack");
    complete_run();
  end

  // Whole run is a few hundred cycles
  initial
  begin
    #200000;
    err_total++;
    $display("BAD %0t watchdog expired", $time);
    complete_run();
  end
endmodule

bind cios_sequencer cios_sva u_cios_sva (.*);
